// file: verilog/atsc_top.v
// Acquisition trigger, mode decode and strobe control with Wishbone registers
`timescale 1ns/1ps
`include "atsc_consts.vh"

module atsc_top (
  input wire clk_i,
  input wire rst_i,
  input wire adc_clk_i,
  input wire ext_strobe_i,
  input wire [2:0] strobe_divisor_jumper_i,
  input wire mode_select_high_i,
  input wire mode_select_low_i,
  input wire software_trigger_input_i,
  input wire sync_trigger_i,
  input wire hard_trigger_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg readout_gate_o,
  output reg single_strobe_o,
  output reg lamp_enable_o,
  output wire cont_strobe_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [5:0] sync_a;
  reg [5:0] sync_b;
  reg adc_clk_d;
  reg [2:0] jump_a;
  reg [2:0] jump_b;
  wire adc_rise;
  wire sel_hi;
  wire sel_lo;
  wire soft_trig;
  wire sync_trig;
  wire hard_trig;
  wire ext_strobe;

  // Two flops each, three for the converter clock; logic reads the second stage, and the converter clock's third for its edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
      adc_clk_d <= 1'b0;
      jump_a <= 3'h0;
      jump_b <= 3'h0;
    end else begin
      sync_a <= {ext_strobe_i, adc_clk_i, mode_select_high_i, mode_select_low_i,
                 software_trigger_input_i, sync_trigger_i ^ hard_trigger_i ^ 1'b0};
      sync_b <= sync_a;
      adc_clk_d <= sync_b[4];
      jump_a <= strobe_divisor_jumper_i;
      jump_b <= jump_a;
    end
  end

  // Separate flops for the edge triggers keep each line distinct
  reg [1:0] edge_a;
  reg [1:0] edge_b;
  always @(posedge clk_i) begin
    if (rst_i) begin
      edge_a <= 2'h0;
      edge_b <= 2'h0;
    end else begin
      edge_a <= {sync_trigger_i, hard_trigger_i};
      edge_b <= edge_a;
    end
  end

  assign ext_strobe = sync_b[5];
  assign adc_rise = sync_b[4] & ~adc_clk_d;
  assign sel_hi = sync_b[3];
  assign sel_lo = sync_b[2];
  assign soft_trig = sync_b[1];
  assign sync_trig = edge_b[1];
  assign hard_trig = edge_b[0];

  // ****************************************
  // Mode decode
  // ****************************************
  reg [1:0] mode;
  reg soft_mode_en;

  // Upper select picks the external clocked modes; lower splits them
  always @* begin
    if (!sel_hi) begin
      mode = soft_mode_en ? `ATSC_MODE_SOFT : `ATSC_MODE_FREE;
    end else if (!sel_lo) begin
      mode = `ATSC_MODE_SYNC;
    end else begin
      mode = `ATSC_MODE_HARD;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  reg [31:0] ctrl;
  reg [31:0] integ;
  reg [31:0] integ_cnt;
  reg [31:0] spectra;
  reg pending;
  reg sync_d;
  reg hard_d;
  reg [1:0] mode_d;

  always @* begin
    soft_mode_en = ctrl[`ATSC_CTRL_POLL_BIT];
  end

  // Byte-lane write merge used for each writable register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire integ_end = adc_rise && (integ_cnt >= integ - `ATSC_INTEG_MIN);
  wire sync_rise = sync_trig & ~sync_d;
  wire hard_rise = hard_trig & ~hard_d;
  reg deliver;
  reg period_start;

  // Which end-of-period events hand a spectrum to the reader
  always @* begin
    deliver = 1'b0;
    period_start = 1'b0;
    case (mode)
      `ATSC_MODE_FREE: begin
        period_start = integ_end;
        deliver = integ_end;
      end
      `ATSC_MODE_SOFT: begin
        period_start = integ_end;
        deliver = integ_end & (soft_trig | pending);
      end
      `ATSC_MODE_SYNC: begin
        period_start = sync_rise;
        deliver = sync_rise & pending;
      end
      default: begin
        period_start = hard_rise;
        deliver = 1'b0;
      end
    endcase
  end

  // Bus slave, integration timing and delivery bookkeeping
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `ATSC_CTRL_RESET;
      integ <= `ATSC_INTEG_RESET;
      integ_cnt <= 32'h0000_0000;
      spectra <= 32'h0000_0000;
      pending <= 1'b0;
      sync_d <= 1'b0;
      hard_d <= 1'b0;
      mode_d <= `ATSC_MODE_FREE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      readout_gate_o <= 1'b0;
      single_strobe_o <= 1'b0;
      lamp_enable_o <= 1'b0;
    end else begin
      sync_d <= sync_trig;
      hard_d <= hard_trig;
      mode_d <= mode;
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          `ATSC_ADDR_CTRL: ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
          `ATSC_ADDR_INTEG: integ <= merge(integ, wb_dat_i, wb_sel_i);
          default: ;
        endcase
      end else if (wb_req) begin
        case (wb_adr_i)
          `ATSC_ADDR_CTRL: wb_dat_o <= ctrl;
          `ATSC_ADDR_INTEG: wb_dat_o <= integ;
          `ATSC_ADDR_STATUS: wb_dat_o <= {27'h0, pending, mode, sel_lo, sel_hi};
          `ATSC_ADDR_COUNT: wb_dat_o <= spectra;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
      // Integration counted on converter clock edges only
      if (period_start) begin
        integ_cnt <= 32'h0000_0000;
      end else if (adc_rise && (mode[1] == 1'b0)) begin
        integ_cnt <= integ_cnt + 32'h0000_0001;
      end
      // A polled trigger arms the next completed scan; no fixed latency.
      // Arming wins over delivery, so every later sync edge delivers again;
      // a mode change drops whatever the old mode had armed.
      if (mode == `ATSC_MODE_SOFT && soft_trig) begin
        pending <= 1'b1;
      end else if (mode == `ATSC_MODE_SYNC && sync_rise) begin
        pending <= 1'b1;
      end else if (deliver || (mode != mode_d)) begin
        pending <= 1'b0;
      end
      if (deliver || (mode == `ATSC_MODE_HARD && hard_rise)) begin
        spectra <= spectra + 32'h0000_0001;
      end
      readout_gate_o <= deliver | (mode == `ATSC_MODE_HARD && hard_rise);
      single_strobe_o <= period_start;
      lamp_enable_o <= ~sel_hi & sel_lo;
    end
  end

  // ****************************************
  // Continuous strobe
  // ****************************************
  atsc_strobe_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .adc_clk_rise_i(adc_rise),
    .ext_strobe_i(ext_strobe),
    .strobe_divisor_jumper_i(jump_b),
    .strobe_o(cont_strobe_o)
  );

endmodule

// file: inc/atsc_consts.vh
// Constants for the acquisition trigger and strobe control block
`ifndef ATSC_CONSTS_VH
`define ATSC_CONSTS_VH

// ****************************************
// Wishbone register offsets (byte addresses)
// ****************************************
`define ATSC_ADDR_CTRL 8'h00
`define ATSC_ADDR_INTEG 8'h04
`define ATSC_ADDR_STATUS 8'h08
`define ATSC_ADDR_COUNT 8'h0C

// ****************************************
// Control register fields
// ****************************************
`define ATSC_CTRL_POLL_BIT 0
`define ATSC_CTRL_RESET 32'h0000_0000
`define ATSC_INTEG_RESET 32'h0000_1000
`define ATSC_INTEG_MIN 32'h0000_0001

// ****************************************
// Jumper codes for the continuous strobe divisor
// ****************************************
`define ATSC_JP_PASS 3'h1
`define ATSC_JP_DIV10 3'h2
`define ATSC_JP_DIV12 3'h3
`define ATSC_JP_DIV14 3'h4
`define ATSC_JP_DIV16 3'h5
`define ATSC_DIV_W 16
`define ATSC_TAP10 4'h9
`define ATSC_TAP12 4'hB
`define ATSC_TAP14 4'hD
`define ATSC_TAP16 4'hF

// ****************************************
// Trigger mode encodings
// ****************************************
`define ATSC_MODE_FREE 2'h0
`define ATSC_MODE_SOFT 2'h1
`define ATSC_MODE_SYNC 2'h2
`define ATSC_MODE_HARD 2'h3

`endif

// file: verilog/atsc_strobe_div.v
// Continuous strobe divider driven by edges of the converter clock
`timescale 1ns/1ps
`include "atsc_consts.vh"

module atsc_strobe_div (
  input wire clk_i,
  input wire rst_i,
  input wire adc_clk_rise_i,
  input wire ext_strobe_i,
  input wire [2:0] strobe_divisor_jumper_i,
  output reg strobe_o
);

  reg [`ATSC_DIV_W-1:0] count;
  reg [3:0] tap;

  // Pick the counter bit whose full period is two to the power of the divisor
  always @* begin
    case (strobe_divisor_jumper_i)
      `ATSC_JP_DIV10: tap = `ATSC_TAP10;
      `ATSC_JP_DIV12: tap = `ATSC_TAP12;
      `ATSC_JP_DIV14: tap = `ATSC_TAP14;
      default: tap = `ATSC_TAP16;
    endcase
  end

  // Counter advances once per converter clock rising edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      count <= {`ATSC_DIV_W{1'b0}};
      strobe_o <= 1'b0;
    end else begin
      if (adc_clk_rise_i) begin
        count <= count + 1'b1;
      end
      if (strobe_divisor_jumper_i == `ATSC_JP_PASS) begin
        strobe_o <= ext_strobe_i;
      end else begin
        strobe_o <= count[tap];
      end
    end
  end

endmodule

// file: test/atsc_monitor.sv
// Port checker for the trigger and strobe block
`timescale 1ns/1ps
module atsc_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire ext_strobe_i,
  input wire [2:0] strobe_divisor_jumper_i,
  input wire mode_select_high_i,
  input wire mode_select_low_i,
  input wire sync_trigger_i,
  input wire hard_trigger_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire readout_gate_o,
  input wire single_strobe_o,
  input wire lamp_enable_o,
  input wire cont_strobe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Edge mode with all inputs still past the synchroniser delay
  sequence s_calm;
    (mode_select_high_i && $stable(mode_select_low_i) && $stable(sync_trigger_i)
      && $stable(hard_trigger_i))[*8];
  endsequence
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack unasked");
  a_gate_pulse: assert property (readout_gate_o |=> !readout_gate_o)
    else $error("gate too long");
  a_flash_pulse: assert property (single_strobe_o |=> !single_strobe_o)
    else $error("flash too long");
  a_edge_quiet: assert property (s_calm |-> !readout_gate_o)
    else $error("delivery without trigger");
  a_lamp_gate: assert property (
    ($stable(mode_select_high_i) && $stable(mode_select_low_i))[*6]
    |-> lamp_enable_o == (!mode_select_high_i && mode_select_low_i)) else $error("lamp");
  a_pass_follow: assert property (
    (strobe_divisor_jumper_i == 3'h1 && $stable(ext_strobe_i))[*6]
    |-> cont_strobe_o == ext_strobe_i) else $error("passthrough");
endmodule
bind atsc_top atsc_monitor u_atsc_monitor (.*);

// file: test/atsc_partner.sv
// Triggering device and converter clock model
`timescale 1ns/1ps
module atsc_partner #(parameter HALF = 4) (
  input wire clk_i,
  input wire soft_req_i,
  input wire soft_hold_i,
  input wire readout_gate_i,
  output reg adc_clk_o = 1'b0,
  output reg soft_trig_o = 1'b0
);
  integer cnt = 0;
  // Locked to clk_i so edge counts map to exact cycles
  always @(posedge clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) adc_clk_o <= ~adc_clk_o;
  end
  // Held high until a delivery shows it was polled
  always @(posedge clk_i) begin
    if (soft_req_i || soft_hold_i) soft_trig_o <= 1'b1;
    else if (readout_gate_i) soft_trig_o <= 1'b0;
  end
endmodule

// file: test/tb_top.sv
// Bench for the trigger and strobe block
`timescale 1ns/1ps
module tb_top;
  reg clk_i, rst_i, ext_strobe_i, mode_select_high_i, mode_select_low_i, wb_we_i;
  reg sync_trigger_i, hard_trigger_i, wb_cyc_i, wb_stb_i, soft_req, soft_hold;
  reg [2:0] strobe_divisor_jumper_i;
  reg [7:0] wb_adr_i;
  reg [31:0] wb_dat_i, rd;
  reg [3:0] wb_sel_i;
  wire [31:0] wb_dat_o;
  wire adc_clk_i, software_trigger_input_i, wb_ack_o, readout_gate_o;
  wire single_strobe_o, lamp_enable_o, cont_strobe_o;
  integer num_errors, cmp_count, rog_n, flash_n, i, n, k, seed, rnd;
  atsc_top u_atsc_top (.*);
  atsc_partner u_atsc_partner (.clk_i(clk_i), .soft_req_i(soft_req),
    .soft_hold_i(soft_hold), .readout_gate_i(readout_gate_o), .adc_clk_o(adc_clk_i),
    .soft_trig_o(software_trigger_input_i));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Deliveries seen at the pin
  always @(posedge clk_i) begin
    if (readout_gate_o === 1'b1) rog_n <= rog_n + 1;
    if (single_strobe_o === 1'b1) flash_n <= flash_n + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // One bounded clock; a spent bound ends the run
  task step(input integer lim);
    begin
      @(posedge clk_i);
      n = n + 1;
      if (n > lim) begin
        num_errors = num_errors + 1;
        test_done;
      end
    end
  endtask
  task wt(input integer c);
    repeat (c) @(posedge clk_i);
  endtask
  task bus(input we, input [7:0] a, input [31:0] d, input [3:0] s);
    begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, s};
      n = 0;
      step(20);
      while (wb_ack_o !== 1'b1) step(20);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      step(21);
    end
  endtask
  // Status {mode, lower, upper} with software mode off
  function [3:0] exp_stat(input h, input l);
    exp_stat = {h, h & l, l, h};
  endfunction
  initial begin
    {ext_strobe_i, mode_select_high_i, mode_select_low_i, sync_trigger_i, hard_trigger_i} = 5'h0;
    {wb_we_i, wb_cyc_i, wb_stb_i, soft_req, soft_hold, wb_adr_i, wb_dat_i, wb_sel_i} = 49'h0;
    {strobe_divisor_jumper_i, rst_i} = 4'h3;
    {num_errors, cmp_count, rog_n, flash_n} = 128'h0;
    seed = 32'hC2D9CEA5;
    wt(10);
    rst_i <= 1'b0;
    // Reset value, one byte lane, unmapped place
    bus(1'b0, 8'h04, 32'h0, 4'hF);
    chk(rd, 32'h1000);
    bus(1'b1, 8'h04, 32'hFFFFFF05, 4'h1);
    bus(1'b0, 8'h04, 32'h0, 4'hF);
    chk(rd, 32'h1005);
    bus(1'b0, 8'h10, 32'h0, 4'hF);
    chk(rd, 32'h0);
    bus(1'b1, 8'h04, 32'h4, 4'hF);
    for (i = 0; i < 4; i = i + 1) begin
      {mode_select_high_i, mode_select_low_i} <= i[1:0];
      wt(8);
      bus(1'b0, 8'h08, 32'h0, 4'hF);
      chk(rd[3:0], exp_stat(i[1], i[0]));
      chk(lamp_enable_o, ~i[1] & i[0]);
    end
    $display("registers and modes end");
    // Free mode runs alone, sync mode waits for its second edge
    mode_select_high_i <= 1'b0;
    k = rog_n;
    wt(500);
    chk(rog_n - k > 9, 1);
    {mode_select_high_i, mode_select_low_i} <= 2'h2;
    wt(10);
    k = rog_n;
    wt(100);
    chk(rog_n, k);
    bus(1'b0, 8'h0C, 32'h0, 4'hF);
    chk(rd, rog_n);
    for (i = 0; i < 3; i = i + 1) begin
      sync_trigger_i <= 1'b1;
      wt(6);
      sync_trigger_i <= 1'b0;
      rnd = $random(seed);
      wt(10 + rnd[3:0]);
    end
    chk(rog_n, k + 2);
    // Hardware mode ignores the sync line
    mode_select_low_i <= 1'b1;
    wt(8);
    k = rog_n;
    sync_trigger_i <= 1'b1;
    wt(6);
    {sync_trigger_i, hard_trigger_i} <= 2'h1;
    n = 0;
    while (rog_n == k) step(20);
    hard_trigger_i <= 1'b0;
    wt(10);
    chk(rog_n, k + 1);
    // Software trigger: quiet, a pulse gets an answer, free when held
    {mode_select_high_i, mode_select_low_i} <= 2'h0;
    bus(1'b1, 8'h00, 32'h1, 4'hF);
    wt(40);
    k = rog_n;
    rnd = flash_n;
    wt(200);
    chk(rog_n, k);
    chk(flash_n - rnd > 5, 1);
    soft_req <= 1'b1;
    wt(1);
    soft_req <= 1'b0;
    n = 0;
    while (rog_n == k) step(1000);
    soft_hold <= 1'b1;
    k = rog_n;
    wt(500);
    chk(rog_n - k > 9, 1);
    soft_hold <= 1'b0;
    $display("triggers end");
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $random(seed);
      ext_strobe_i <= rnd[0];
      wt(8);
      chk(cont_strobe_o, rnd[0]);
    end
    // Third toggle gap is a full half period
    strobe_divisor_jumper_i <= 3'h2;
    for (i = 0; i < 3; i = i + 1) begin
      rd = cont_strobe_o;
      n = 0;
      while (cont_strobe_o === rd[0]) step(9000);
    end
    chk(n, 4096);
    $display("strobe end");
    test_done;
  end
endmodule
